// ### design/pbmc_pkg.sv
// Shared constants and types of the basic mode control block.
`default_nettype none

package pbmc_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SW_RESET_NS   = 1000;
  localparam int SW_RESET_CYC  = (SW_RESET_NS * 1000) / CLK_PERIOD_PS;
  localparam int DEAD_TIME_NS  = 5000;
  localparam int DEAD_CYC      = (DEAD_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [9:0] SW_RESET_LOAD = 10'(SW_RESET_CYC);
  localparam logic [9:0] DEAD_LOAD     = 10'(DEAD_CYC);
  localparam logic [9:0] TMR_IDLE      = 10'h000;
  localparam logic [9:0] TMR_LAST      = 10'h001;

  // ---------------------------------------------------------------------------
  // Register map and field positions
  // ---------------------------------------------------------------------------
  localparam logic [4:0]  BMC_ADDR      = 5'h00;
  localparam logic [15:0] BMC_RESET_VAL = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
  localparam int B_RESET   = 15;
  localparam int B_LOOP    = 14;
  localparam int B_SPEED   = 13;
  localparam int B_AN_EN   = 12;
  localparam int B_PDOWN   = 11;
  localparam int B_ISOLATE = 10;
  localparam int B_RESTART = 9;
  localparam int B_DUPLEX  = 8;
  localparam int B_COLTEST = 7;

  // ---------------------------------------------------------------------------
  // Management frame
  // ---------------------------------------------------------------------------
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [4:0] HDR_LAST      = 5'h0C;
  localparam logic [4:0] TA_LAST       = 5'h01;
  localparam logic [4:0] DATA_LAST     = 5'h0F;
  localparam logic [4:0] DATA_BITS     = 5'h10;
  localparam logic [3:0] NIB_ZERO      = 4'h0;

  typedef enum logic [2:0] {
    MD_PRE,
    MD_HDR,
    MD_TA_RD,
    MD_RD,
    MD_TA_WR,
    MD_WR
  } pbmc_md_type;

endpackage : pbmc_pkg

`default_nettype wire

// ### design/pbmc_cfg_if.sv
// Control levels passed from the register block to the MAC-side datapath.
`default_nettype none

interface pbmc_cfg_if;
  logic loopback;
  logic isolate;
  logic hold;
  logic coltest;
  logic rx_blank;

  modport ctrl (output loopback, output isolate, output hold, output coltest, output rx_blank);
  modport dp   (input loopback, input isolate, input hold, input coltest, input rx_blank);
endinterface : pbmc_cfg_if

`default_nettype wire

// ### design/pbmc_timer.sv
// One-shot down counter with busy level and a done pulse.
`default_nettype none

module pbmc_timer
#(
  parameter logic [9:0] LOAD = 10'h001
)
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  logic [9:0] cnt_reg;
  wire logic [9:0] cnt_next = start_i ? LOAD :
                              (cnt_reg != pbmc_pkg::TMR_IDLE) ? cnt_reg - 10'h001 : cnt_reg;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= pbmc_pkg::TMR_IDLE;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      busy_o  <= (cnt_next != pbmc_pkg::TMR_IDLE);
      done_o  <= (cnt_reg == pbmc_pkg::TMR_LAST) & ~start_i;
    end
  end

endmodule : pbmc_timer

`default_nettype wire

// ### design/pbmc_datapath.sv
// MAC-side data gating: loopback, isolation, power down and collision test.
`default_nettype none

module pbmc_datapath
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  pbmc_cfg_if.dp          cfg,
  input  wire logic [3:0] mii_txd_i,
  input  wire logic       mii_tx_en_i,
  input  wire logic [3:0] line_rxd_i,
  input  wire logic       line_rx_dv_i,
  output logic      [3:0] mii_rxd_o,
  output logic            mii_rx_dv_o,
  output logic            mii_col_o,
  output logic      [3:0] line_txd_o,
  output logic            line_tx_en_o
);

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  wire logic       live    = ~cfg.hold & ~cfg.isolate;
  wire logic       to_line = live & ~cfg.loopback;
  wire logic [3:0] rxd_sel = cfg.loopback ? mii_txd_i : line_rxd_i;
  wire logic       dv_sel  = (cfg.loopback ? mii_tx_en_i : line_rx_dv_i) & ~cfg.rx_blank;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mii_rxd_o    <= pbmc_pkg::NIB_ZERO;
      mii_rx_dv_o  <= 1'b0;
      mii_col_o    <= 1'b0;
      line_txd_o   <= pbmc_pkg::NIB_ZERO;
      line_tx_en_o <= 1'b0;
    end
    else
    begin
      mii_rxd_o    <= live ? rxd_sel : pbmc_pkg::NIB_ZERO;
      mii_rx_dv_o  <= live & dv_sel;
      mii_col_o    <= live & cfg.coltest & mii_tx_en_i;
      line_txd_o   <= to_line ? mii_txd_i : pbmc_pkg::NIB_ZERO;
      line_tx_en_o <= to_line & mii_tx_en_i;
    end
  end

  property p_col_on;
    live && cfg.coltest && mii_tx_en_i |=> mii_col_o;
  endproperty
  a_col_on: assert property (p_col_on)
    else $error("Collision not raised after transmit enable.");

  property p_col_off;
    !mii_tx_en_i |=> !mii_col_o;
  endproperty
  a_col_off: assert property (p_col_off)
    else $error("Collision not dropped after transmit enable fell.");

  property p_dead;
    $rose(cfg.rx_blank) |-> ##1 !mii_rx_dv_o [*8];
  endproperty
  a_dead: assert property (p_dead)
    else $error("Receive valid shown during loopback dead time.");

  property p_isolate;
    cfg.isolate |=> !mii_rx_dv_o && !line_tx_en_o && !mii_col_o;
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("Data passed while isolated.");

endmodule : pbmc_datapath

`default_nettype wire

// ### design/pbmc_top.sv
// Basic mode control register, its serial management port and control outputs.
`default_nettype none

// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------

module pbmc_top
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       mdc_i,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe_n_o,
  input  wire logic [4:0] phy_addr_i,
  input  wire logic       strap_speed_100_i,
  input  wire logic       strap_an_enable_i,
  input  wire logic       strap_full_duplex_i,
  input  wire logic       fiber_mode_enable_i,
  input  wire logic       powerdown_interrupt_pin_n_i,
  input  wire logic       an_started_i,
  input  wire logic       an_speed_100_i,
  input  wire logic       an_full_duplex_i,
  output logic            an_enable_o,
  output logic            an_restart_o,
  output logic            speed_100_o,
  output logic            full_duplex_o,
  output logic            power_down_o,
  output logic            sw_reset_busy_o,
  input  wire logic [3:0] mii_txd_i,
  input  wire logic       mii_tx_en_i,
  input  wire logic [3:0] line_rxd_i,
  input  wire logic       line_rx_dv_i,
  output logic      [3:0] mii_rxd_o,
  output logic            mii_rx_dv_o,
  output logic            mii_col_o,
  output logic      [3:0] line_txd_o,
  output logic            line_tx_en_o
);

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  pbmc_pkg::pbmc_md_type state_reg;
  pbmc_pkg::pbmc_md_type state_next;
  logic        mdc_d_reg;
  logic [5:0]  ones_reg;
  logic [5:0]  ones_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;
  logic [12:0] hdr_reg;
  logic [12:0] hdr_next;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic        mdo_next;
  logic        oe_n_next;
  logic        wr_reg;
  logic        wr_next;
  logic        strap_load_reg;
  logic        loop_reg;
  logic        speed_reg;
  logic        an_en_reg;
  logic        pdown_reg;
  logic        isolate_reg;
  logic        restart_reg;
  logic        duplex_reg;
  logic        coltest_reg;
  logic        rst_done;
  logic        dead_busy;
  logic [15:0] bmc_val;

  pbmc_cfg_if cfg ();

  // ---------------------------------------------------------------------------
  // Management frame decode
  // ---------------------------------------------------------------------------
  wire logic        mdc_rise  = mdc_i & ~mdc_d_reg;
  wire logic        ones_full = (ones_reg >= pbmc_pkg::PREAMBLE_ONES);
  wire logic [12:0] hdr_in    = {hdr_reg[11:0], mdio_i};
  wire logic [1:0]  hdr_op    = hdr_in[11:10];
  wire logic        hdr_ok    = hdr_in[12] & (hdr_in[9:5] == phy_addr_i);
  wire logic        hdr_is_bmc = (hdr_in[4:0] == pbmc_pkg::BMC_ADDR);
  wire logic [15:0] rd_data   = hdr_is_bmc ? bmc_val : pbmc_pkg::UNMAPPED_READ;

  always_comb
  begin
    state_next = state_reg;
    ones_next  = ones_reg;
    cnt_next   = cnt_reg;
    hdr_next   = hdr_reg;
    shift_next = shift_reg;
    mdo_next   = mdio_o;
    oe_n_next  = mdio_oe_n_o;
    wr_next    = 1'b0;
    if (mdc_rise)
    begin
      unique case (state_reg)
        pbmc_pkg::MD_PRE:
        begin
          cnt_next = 5'h00;
          if (mdio_i)
          begin
            ones_next = ones_full ? ones_reg : ones_reg + 6'h01;
          end
          else
          begin
            ones_next = 6'h00;
            if (ones_full)
            begin
              state_next = pbmc_pkg::MD_HDR;
            end
          end
        end
        pbmc_pkg::MD_HDR:
        begin
          hdr_next = hdr_in;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == pbmc_pkg::HDR_LAST)
          begin
            cnt_next = 5'h00;
            if (hdr_ok && (hdr_op == pbmc_pkg::OP_READ))
            begin
              state_next = pbmc_pkg::MD_TA_RD;
              shift_next = rd_data;
            end
            else if (hdr_ok && (hdr_op == pbmc_pkg::OP_WRITE))
            begin
              state_next = pbmc_pkg::MD_TA_WR;
            end
            else
            begin
              state_next = pbmc_pkg::MD_PRE;
            end
          end
        end
        pbmc_pkg::MD_TA_RD:
        begin
          mdo_next   = 1'b0;
          oe_n_next  = 1'b0;
          state_next = pbmc_pkg::MD_RD;
        end
        pbmc_pkg::MD_RD:
        begin
          if (cnt_reg == pbmc_pkg::DATA_BITS)
          begin
            mdo_next   = 1'b0;
            oe_n_next  = 1'b1;
            state_next = pbmc_pkg::MD_PRE;
          end
          else
          begin
            mdo_next   = shift_reg[15];
            shift_next = {shift_reg[14:0], 1'b0};
            cnt_next   = cnt_reg + 5'h01;
          end
        end
        pbmc_pkg::MD_TA_WR:
        begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == pbmc_pkg::TA_LAST)
          begin
            cnt_next   = 5'h00;
            state_next = pbmc_pkg::MD_WR;
          end
        end
        pbmc_pkg::MD_WR:
        begin
          shift_next = {shift_reg[14:0], mdio_i};
          cnt_next   = cnt_reg + 5'h01;
          if (cnt_reg == pbmc_pkg::DATA_LAST)
          begin
            wr_next    = 1'b1;
            state_next = pbmc_pkg::MD_PRE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg   <= pbmc_pkg::MD_PRE;
      mdc_d_reg   <= 1'b0;
      ones_reg    <= 6'h00;
      cnt_reg     <= 5'h00;
      hdr_reg     <= 13'h0000;
      shift_reg   <= 16'h0000;
      mdio_o      <= 1'b0;
      mdio_oe_n_o <= 1'b1;
      wr_reg      <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      mdc_d_reg   <= mdc_i;
      ones_reg    <= ones_next;
      cnt_reg     <= cnt_next;
      hdr_reg     <= hdr_next;
      shift_reg   <= shift_next;
      mdio_o      <= mdo_next;
      mdio_oe_n_o <= oe_n_next;
      wr_reg      <= wr_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Register write decode
  // ---------------------------------------------------------------------------
  wire logic [15:0] wd        = shift_reg;
  wire logic        bmc_wr    = wr_reg & (hdr_reg[4:0] == pbmc_pkg::BMC_ADDR) & ~sw_reset_busy_o;
  wire logic        start_rst = bmc_wr & wd[pbmc_pkg::B_RESET];
  wire logic        norm_wr   = bmc_wr & ~wd[pbmc_pkg::B_RESET];
  wire logic        load_def  = strap_load_reg | rst_done;
  wire logic        pin_low   = ~powerdown_interrupt_pin_n_i;
  wire logic        restart_set = norm_wr & wd[pbmc_pkg::B_RESTART] & wd[pbmc_pkg::B_AN_EN];

  wire logic loop_next    = load_def ? 1'b0 : norm_wr ? wd[pbmc_pkg::B_LOOP] : loop_reg;
  wire logic speed_next   = load_def ? strap_speed_100_i :
                            norm_wr ? wd[pbmc_pkg::B_SPEED] : speed_reg;
  wire logic an_en_next   = load_def ? strap_an_enable_i & ~fiber_mode_enable_i :
                            norm_wr ? wd[pbmc_pkg::B_AN_EN] : an_en_reg;
  wire logic pdown_next   = pin_low ? 1'b1 : load_def ? 1'b0 :
                            norm_wr ? wd[pbmc_pkg::B_PDOWN] : pdown_reg;
  wire logic isolate_next = load_def ? 1'b0 : norm_wr ? wd[pbmc_pkg::B_ISOLATE] : isolate_reg;
  wire logic duplex_next  = load_def ? strap_full_duplex_i :
                            norm_wr ? wd[pbmc_pkg::B_DUPLEX] : duplex_reg;
  wire logic coltest_next = load_def ? 1'b0 : norm_wr ? wd[pbmc_pkg::B_COLTEST] : coltest_reg;
  wire logic restart_next = restart_set ? 1'b1 :
                            (an_started_i | load_def) ? 1'b0 : restart_reg;

  // A restart write of zero does not clear the request; only the start report from the
  // negotiation engine or a load of defaults clears it, and the process then runs on regardless.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strap_load_reg <= 1'b1;
      loop_reg       <= 1'b0;
      speed_reg      <= 1'b0;
      an_en_reg      <= 1'b0;
      pdown_reg      <= 1'b0;
      isolate_reg    <= 1'b0;
      restart_reg    <= 1'b0;
      duplex_reg     <= 1'b0;
      coltest_reg    <= 1'b0;
    end
    else
    begin
      strap_load_reg <= 1'b0;
      loop_reg       <= loop_next;
      speed_reg      <= speed_next;
      an_en_reg      <= an_en_next;
      pdown_reg      <= pdown_next;
      isolate_reg    <= isolate_next;
      restart_reg    <= restart_next;
      duplex_reg     <= duplex_next;
      coltest_reg    <= coltest_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Read value
  // ---------------------------------------------------------------------------
  always_comb
  begin
    bmc_val                      = pbmc_pkg::BMC_RESET_VAL;
    bmc_val[pbmc_pkg::B_RESET]   = sw_reset_busy_o;
    bmc_val[pbmc_pkg::B_LOOP]    = loop_reg;
    bmc_val[pbmc_pkg::B_SPEED]   = speed_reg;
    bmc_val[pbmc_pkg::B_AN_EN]   = an_en_reg;
    bmc_val[pbmc_pkg::B_PDOWN]   = pdown_reg;
    bmc_val[pbmc_pkg::B_ISOLATE] = isolate_reg;
    bmc_val[pbmc_pkg::B_RESTART] = restart_reg;
    bmc_val[pbmc_pkg::B_DUPLEX]  = duplex_reg;
    bmc_val[pbmc_pkg::B_COLTEST] = coltest_reg;
  end

  // ---------------------------------------------------------------------------
  // Effective controls
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      an_enable_o   <= 1'b0;
      an_restart_o  <= 1'b0;
      speed_100_o   <= 1'b0;
      full_duplex_o <= 1'b0;
      power_down_o  <= 1'b0;
    end
    else
    begin
      an_enable_o   <= an_en_reg;
      an_restart_o  <= restart_reg;
      speed_100_o   <= an_en_reg ? an_speed_100_i : speed_reg;
      full_duplex_o <= an_en_reg ? an_full_duplex_i : duplex_reg;
      power_down_o  <= pdown_reg | pin_low;
    end
  end

  pbmc_timer #(
    .LOAD (pbmc_pkg::SW_RESET_LOAD)
  ) u_reset_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (start_rst),
    .busy_o    (sw_reset_busy_o),
    .done_o    (rst_done)
  );

  pbmc_timer #(
    .LOAD (pbmc_pkg::DEAD_LOAD)
  ) u_dead_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (loop_next & ~loop_reg),
    .busy_o    (dead_busy),
    .done_o    ()
  );

  assign cfg.loopback = loop_reg;
  assign cfg.isolate  = isolate_reg;
  assign cfg.hold     = pdown_reg | pin_low | sw_reset_busy_o;
  assign cfg.coltest  = coltest_reg;
  assign cfg.rx_blank = dead_busy;

  pbmc_datapath u_datapath (
    .ref_clk_i    (ref_clk_i),
    .rst_i        (rst_i),
    .cfg          (cfg.dp),
    .mii_txd_i    (mii_txd_i),
    .mii_tx_en_i  (mii_tx_en_i),
    .line_rxd_i   (line_rxd_i),
    .line_rx_dv_i (line_rx_dv_i),
    .mii_rxd_o    (mii_rxd_o),
    .mii_rx_dv_o  (mii_rx_dv_o),
    .mii_col_o    (mii_col_o),
    .line_txd_o   (line_txd_o),
    .line_tx_en_o (line_tx_en_o)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_rst_hold;
    start_rst |=> sw_reset_busy_o [*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("Reset bit did not read one during reset.");

  property p_restrap;
    rst_done |=> speed_reg == $past(strap_speed_100_i) && duplex_reg == $past(strap_full_duplex_i);
  endproperty
  a_restrap: assert property (p_restrap)
    else $error("Straps not reloaded after reset.");

  property p_fiber;
    rst_done && fiber_mode_enable_i |=> !an_en_reg;
  endproperty
  a_fiber: assert property (p_fiber)
    else $error("Negotiation enabled in fiber mode after reset.");

  property p_pin;
    pin_low |=> pdown_reg && cfg.hold ##1 power_down_o;
  endproperty
  a_pin: assert property (p_pin)
    else $error("Power down pin did not set power down.");

  property p_restart_ign;
    norm_wr && !wd[pbmc_pkg::B_AN_EN] && !restart_reg |=> !restart_reg && !an_restart_o;
  endproperty
  a_restart_ign: assert property (p_restart_ign)
    else $error("Restart taken while negotiation disabled.");

  property p_restart_hold;
    restart_reg && !an_started_i && !load_def |=> restart_reg;
  endproperty
  a_restart_hold: assert property (p_restart_hold)
    else $error("Restart bit cleared before negotiation started.");

  property p_forced;
    !an_en_reg |=> speed_100_o == $past(speed_reg) && full_duplex_o == $past(duplex_reg);
  endproperty
  a_forced: assert property (p_forced)
    else $error("Forced speed or duplex not applied.");

  property p_mdio_release;
    state_reg == pbmc_pkg::MD_PRE && !mdc_rise |=> mdio_oe_n_o;
  endproperty
  a_mdio_release: assert property (p_mdio_release)
    else $error("Management pin driven outside a read.");

endmodule : pbmc_top

`default_nettype wire

// ### tb/pbmc_mgmt_model.sv
// Station management controller model that runs frames on the management lines.
`default_nettype none

module pbmc_mgmt_model
(
  input  wire logic ref_clk_i,
  input  wire logic dev_mdio_i,
  input  wire logic dev_oe_n_i,
  output logic      mdc_o,
  output logic      mdio_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_en = 1'b0;
  logic drv_bit = 1'b1;
  // A line that nobody drives floats to the pull-up level.
  assign mdio_o = !dev_oe_n_i ? dev_mdio_i : (drv_en ? drv_bit : 1'b1);
  initial
  begin
    mdc_o = 1'b0;
  end
  // One management clock of eight reference clocks; s is the level at the rise.
  task automatic bit_cyc(input logic en, input logic b, output logic s);
    @(negedge ref_clk_i);
    mdc_o = 1'b0;
    drv_en = en;
    drv_bit = b;
    repeat (4) @(negedge ref_clk_i);
    mdc_o = 1'b1;
    s = mdio_o;
    repeat (3) @(negedge ref_clk_i);
  endtask : bit_cyc
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [45:0] hdr;
    logic        s;
    hdr = {32'hFFFF_FFFF, 2'h1, rd ? 2'h2 : 2'h1, pa, ra};
    for (int i = 45; i >= 0; i--)
      bit_cyc(1'b1, hdr[i], s);
    for (int i = 0; i < 2; i++)
      bit_cyc(!rd, i == 0, s);
    for (int i = 15; i >= 0; i--)
    begin
      bit_cyc(!rd, wd[i], s);
      rdat[i] = s;
    end
    bit_cyc(1'b0, 1'b1, s);
  endtask : frame
endmodule : pbmc_mgmt_model

`default_nettype wire

// ### tb/phy_basic_mode_control_tb_top.sv
// Self-checking bench of the basic mode control block.
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t got %h expected %h", $time, a, b); end end

module phy_basic_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  int err_total = 0;
  int n_tests = 0;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic mdc, mdio, mdo, oe_n, sp, an, fd, fx, pd_n, an_st, an_sp, an_fd, txen, lrxdv;
  logic an_en, an_rs, spd, dup, pdn, busy, rxdv, col, ltxen;
  logic [3:0] txd, lrxd, rxd, ltxd;
  always #2.5 ref_clk = !ref_clk;
  pbmc_mgmt_model mgmt (.ref_clk_i(ref_clk), .dev_mdio_i(mdo), .dev_oe_n_i(oe_n),
    .mdc_o(mdc), .mdio_o(mdio));
  pbmc_top DUT (.ref_clk_i(ref_clk), .rst_i(rst), .mdc_i(mdc), .mdio_i(mdio),
    .mdio_o(mdo), .mdio_oe_n_o(oe_n), .phy_addr_i(5'h05), .strap_speed_100_i(sp),
    .strap_an_enable_i(an), .strap_full_duplex_i(fd), .fiber_mode_enable_i(fx),
    .powerdown_interrupt_pin_n_i(pd_n), .an_started_i(an_st), .an_speed_100_i(an_sp),
    .an_full_duplex_i(an_fd), .an_enable_o(an_en), .an_restart_o(an_rs),
    .speed_100_o(spd), .full_duplex_o(dup), .power_down_o(pdn), .sw_reset_busy_o(busy),
    .mii_txd_i(txd), .mii_tx_en_i(txen), .line_rxd_i(lrxd), .line_rx_dv_i(lrxdv),
    .mii_rxd_o(rxd), .mii_rx_dv_o(rxdv), .mii_col_o(col), .line_txd_o(ltxd),
    .line_tx_en_o(ltxen));
  task automatic conclude();
    $display("errors %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mgmt.frame(1'b0, pa, ra, d, x);
    cyc(3);
  endtask : wr
  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] x;
    mgmt.frame(1'b1, 5'h05, ra, 16'h0000, x);
    `CHK(x, e)
    `CHK(oe_n, 1'b1)
  endtask : rd_chk
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_straps();
    rd_chk(5'h00, 16'h2100);
    `CHK(an_en, 1'b0)
    `CHK({spd, dup}, 2'h3)
  endtask : t_straps
  task automatic t_soft();
    fx = 1'b0;
    wr(5'h05, 5'h00, 16'h8000);
    `CHK(busy, 1'b1)
    for (int i = 0; i < 300 && busy !== 1'b0; i++)
      cyc(1);
    `CHK(busy, 1'b0)
    cyc(3);
    rd_chk(5'h00, 16'h3100);
  endtask : t_soft
  task automatic t_neg();
    `CHK({spd, dup}, 2'h0)
    wr(5'h05, 5'h00, 16'h1200);
    `CHK(an_rs, 1'b1)
    rd_chk(5'h00, 16'h1200);
    wr(5'h05, 5'h00, 16'h1000);
    `CHK(an_rs, 1'b1)
    an_st = 1'b1;
    cyc(1);
    an_st = 1'b0;
    cyc(3);
    `CHK(an_rs, 1'b0)
    wr(5'h05, 5'h00, 16'h0200);
    `CHK(an_rs, 1'b0)
  endtask : t_neg
  task automatic t_force();
    wr(5'h05, 5'h00, 16'h2100);
    `CHK({spd, dup}, 2'h3)
    wr(5'h05, 5'h00, 16'h0000);
    `CHK({spd, dup}, 2'h0)
    wr(5'h06, 5'h00, 16'h2100);
    wr(5'h05, 5'h01, 16'h2100);
    `CHK({spd, dup}, 2'h0)
    rd_chk(5'h01, 16'h0000);
  endtask : t_force
  task automatic t_pd_iso();
    {lrxdv, lrxd, txen, txd} = 10'h2B3;
    cyc(2);
    `CHK({rxdv, rxd, ltxen, ltxd}, 10'h2B3)
    wr(5'h05, 5'h00, 16'h0800);
    `CHK({pdn, rxdv, ltxen}, 3'h4)
    pd_n = 1'b0;
    wr(5'h05, 5'h00, 16'h0000);
    `CHK(pdn, 1'b1)
    rd_chk(5'h00, 16'h0800);
    pd_n = 1'b1;
    wr(5'h05, 5'h00, 16'h0400);
    `CHK({pdn, rxdv, ltxen}, 3'h0)
    rd_chk(5'h00, 16'h0400);
  endtask : t_pd_iso
  task automatic t_loop_col();
    wr(5'h05, 5'h00, 16'h4000);
    `CHK({rxdv, ltxen}, 2'h0)
    cyc(1100);
    `CHK({rxdv, rxd}, 5'h13)
    wr(5'h05, 5'h00, 16'h0080);
    txen = 1'b0;
    cyc(2);
    `CHK(col, 1'b0)
    txen = 1'b1;
    cyc(2);
    `CHK(col, 1'b1)
  endtask : t_loop_col
  initial
  begin
    {sp, an, fd, fx, pd_n, an_st, an_sp, an_fd, txen, lrxdv} = 10'h3E0;
    {txd, lrxd} = 8'h00;
    cyc(5);
    rst = 1'b0;
    cyc(3);
    t_straps();
    t_soft();
    t_neg();
    t_force();
    t_pd_iso();
    t_loop_col();
    conclude();
  end
  initial
  begin
    #400000;
    err_total++;
    conclude();
  end
endmodule : phy_basic_mode_control_tb_top

`default_nettype wire
